// ===== hw/itw_top.sv
// Seven-bit interval timer with a watchdog extension.
// Assumes one CPU register-file access per cycle and that
// wdt_reset is fed back into the device reset tree (rst_b).
`timescale 1ns/1ps

module itw_top (
  input  wire logic              sys_clk,        // System clock, 10 MHz.
  input  wire logic              rst_b,          // Synchronous reset, active low.
  input  wire itw_pkg::itw_rf_req_t rf_req,      // Register file request.
  output logic [3:0]             rf_rdata,       // Read data, one cycle after rd.
  input  wire logic              irq_clear,      // Clears the interval flag.
  output logic                   interval_irq,   // Interval request flag.
  output logic                   wdt_running,    // Watchdog started.
  output logic                   wdt_reset       // One-cycle system reset request.
);
  import itw_pkg::*;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  wire logic hit_itm;
  wire logic hit_wdt;
  wire logic itm_wr;
  wire logic wdt_wr;
  wire logic clr_wr;
  wire logic start_wr;
  wire logic svc_wr;

  assign hit_itm  = (rf_req.addr == ITM_MODE_ADDR);
  assign hit_wdt  = (rf_req.addr == WDT_MODE_ADDR);
  assign itm_wr   = rf_req.wr & hit_itm;
  assign wdt_wr   = rf_req.wr & hit_wdt;
  // Writing 0 to any of the action bits does nothing.
  assign clr_wr   = itm_wr & rf_req.data[ITM_CLR_BIT];
  assign start_wr = wdt_wr & rf_req.data[WDT_START_BIT];
  assign svc_wr   = wdt_wr & rf_req.data[WDT_SVC_BIT];

  // ****************************************************************
  // Mode register
  // ****************************************************************
  logic              tap_sel;
  logic [1:0]        ck_sel;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tap_sel <= ITM_MODE_RST[ITM_TAP_BIT];
      ck_sel  <= ITM_MODE_RST[ITM_CK_HI_BIT:ITM_CK_LO_BIT];
    end else if (itm_wr) begin
      tap_sel <= rf_req.data[ITM_TAP_BIT];
      ck_sel  <= rf_req.data[ITM_CK_HI_BIT:ITM_CK_LO_BIT];
    end
  end

  // ****************************************************************
  // Prescaler and count pulse
  // ****************************************************************
  logic [PRE_W-1:0]  pre;
  wire logic [PRE_W-1:0] pre_mask;
  wire logic         cnt_pulse;

  // The code order is not monotonic in rate, so each code names its mask.
  assign pre_mask = (ck_sel == CK_DIV16)    ? MASK_DIV16 :
                    (ck_sel == CK_DIV16384) ? MASK_DIV16384 :
                    (ck_sel == CK_DIV4096)  ? MASK_DIV4096 :
                                              MASK_DIV512;
  assign cnt_pulse = ((pre & pre_mask) == pre_mask);

  // Clearing the prescaler too gives a full interval after a clear,
  // so servicing by clear is never cut short by a stale fraction.
  always_ff @(posedge sys_clk) begin
    if (!rst_b || clr_wr)
      pre <= PRE_RST;
    else
      pre <= pre + 1'b1;
  end

  // ****************************************************************
  // Interval counter
  // ****************************************************************
  logic [CNT_W-1:0]  cnt;
  wire logic         ovf;
  wire logic         tap32;
  wire logic         interval_evt;

  assign ovf          = cnt_pulse & (cnt == TAP128_LAST);
  assign tap32        = cnt_pulse & (cnt[4:0] == TAP32_LAST);
  assign interval_evt = tap_sel ? tap32 : ovf;

  always_ff @(posedge sys_clk) begin
    if (!rst_b || clr_wr)
      cnt <= CNT_RST;
    else if (cnt_pulse)
      cnt <= cnt + 1'b1;
  end

  // ****************************************************************
  // Interval flag
  // ****************************************************************
  // A new interval in the cycle of a clear keeps the flag set.
  always_ff @(posedge sys_clk) begin
    if (!rst_b)
      interval_irq <= 1'b0;
    else if (interval_evt)
      interval_irq <= 1'b1;
    else if (irq_clear)
      interval_irq <= 1'b0;
  end

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  logic              carry_div;
  wire logic         wdt_fire;

  // The carry flop acts as the one-bit divider above the counter.
  assign wdt_fire = wdt_running & ovf & carry_div;

  // Only reset clears the run bit; a start write never touches cnt.
  always_ff @(posedge sys_clk) begin
    if (!rst_b)
      wdt_running <= 1'b0;
    else if (start_wr)
      wdt_running <= 1'b1;
  end

  // An overflow in the same cycle as a service still counts.
  always_ff @(posedge sys_clk) begin
    if (!rst_b || wdt_fire)
      carry_div <= 1'b0;
    else if (wdt_running && ovf)
      carry_div <= 1'b1;
    else if (svc_wr)
      carry_div <= 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b)
      wdt_reset <= 1'b0;
    else
      wdt_reset <= wdt_fire;
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  wire logic [3:0]   itm_view;
  wire logic [3:0]   next_rdata;

  // Action bits hold no state and read as zero.
  assign itm_view   = {tap_sel, 1'b0, ck_sel};
  assign next_rdata = !rf_req.rd ? rf_rdata :
                      hit_itm    ? itm_view :
                                   4'h0;

  always_ff @(posedge sys_clk) begin
    if (!rst_b)
      rf_rdata <= 4'h0;
    else
      rf_rdata <= next_rdata;
  end

  // ****************************************************************
  // Check helpers
  // ****************************************************************
  // Counts cycles since the last count pulse, apart from the prescaler, so that
  // a wrong mask or a missed prescaler clear shows up as a gap of wrong length.
  // A mode write without a clear leaves the prescaler part way through a period,
  // so the gap that follows such a write is not checked.
  logic [PRE_W-1:0]      pulse_gap;
  logic                  gap_clean;
  wire logic [PRE_W-1:0] gap_want;

  assign gap_want = (ck_sel == CK_DIV16)    ? MASK_DIV16 :
                    (ck_sel == CK_DIV16384) ? MASK_DIV16384 :
                    (ck_sel == CK_DIV4096)  ? MASK_DIV4096 :
                                              MASK_DIV512;

  always_ff @(posedge sys_clk) begin
    if (!rst_b || clr_wr || cnt_pulse)
      pulse_gap <= PRE_RST;
    else
      pulse_gap <= pulse_gap + 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b || clr_wr)
      gap_clean <= 1'b1;
    else if (itm_wr)
      gap_clean <= 1'b0;
    else if (cnt_pulse)
      gap_clean <= 1'b1;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  div16_space_a: assert property (
    (ck_sel == CK_DIV16 && cnt_pulse && !clr_wr) |=> !cnt_pulse [*8])
    else $error("count pulse too close in divide-by-16 mode");

  clear_cnt_a: assert property (
    clr_wr |=> (cnt == CNT_RST) && !cnt_pulse)
    else $error("counter not cleared by clear write");

  clear_read_a: assert property (
    (rf_req.rd && hit_itm) |=> (rf_rdata[ITM_CLR_BIT] == 1'b0))
    else $error("clear bit read back as one");

  tap32_a: assert property (
    (tap_sel && tap32 && !irq_clear) |=> interval_irq)
    else $error("short interval did not set flag");

  start_keep_a: assert property (
    (start_wr && !clr_wr && !cnt_pulse) |=> (cnt == $past(cnt)) && wdt_running)
    else $error("start write disturbed the counter");

  run_sticky_a: assert property (
    wdt_running |=> wdt_running)
    else $error("watchdog stopped while running");

  wdt_read_a: assert property (
    (rf_req.rd && hit_wdt) |=> (rf_rdata == 4'h0))
    else $error("watchdog register read nonzero");

  service_a: assert property (
    (svc_wr && !ovf && !wdt_fire) |=> !carry_div ##1 !wdt_reset)
    else $error("service did not clear carry flop");

  fire_a: assert property (
    (wdt_running && ovf && carry_div) |=> wdt_reset ##1 !wdt_reset)
    else $error("missed or stretched watchdog reset");

  no_fire_a: assert property (
    (!wdt_running || !carry_div) |=> !wdt_reset)
    else $error("watchdog reset without armed carry");

  irq_set_a: assert property (
    interval_evt |=> interval_irq)
    else $error("interval event lost");

  // ****************************************************************
  // Checks on counting, flags, read path and the watchdog path
  // ****************************************************************
  pulse_space_a: assert property (
    gap_clean |-> (cnt_pulse == (pulse_gap == gap_want)))
    else $error("count pulse spacing does not match the selected rate");

  clear_pre_a: assert property (
    clr_wr |=> (pre == PRE_RST))
    else $error("prescaler not cleared by clear write");

  keep_count_a: assert property (
    (itm_wr && !clr_wr && !cnt_pulse) |=> (cnt == $past(cnt)))
    else $error("mode write without clear moved the counter");

  tap128_a: assert property (
    (!tap_sel && ovf && !irq_clear) |=> interval_irq)
    else $error("long interval did not set flag");

  irq_clear_a: assert property (
    (irq_clear && !interval_evt) |=> !interval_irq)
    else $error("interval flag not cleared");

  idle_carry_a: assert property (
    !wdt_running |-> !carry_div)
    else $error("carry flop armed while watchdog stopped");

  carry_arm_a: assert property (
    (wdt_running && ovf && !carry_div) |=> carry_div)
    else $error("overflow did not arm the carry flop");

  start_clear_a: assert property (
    (wdt_wr && !rf_req.data[WDT_START_BIT] && wdt_running) |=> wdt_running)
    else $error("zero write stopped the watchdog");

  svc_zero_a: assert property (
    (wdt_wr && !rf_req.data[WDT_SVC_BIT] && !ovf) |=> (carry_div == $past(carry_div)))
    else $error("zero service write changed the carry flop");

  fire_cause_a: assert property (
    wdt_reset |-> ($past(wdt_running) && $past(ovf) && $past(carry_div)))
    else $error("watchdog reset without overflow on armed carry");

  reset_pulse_a: assert property (
    wdt_reset |=> !wdt_reset)
    else $error("watchdog reset longer than one cycle");

  rdata_hold_a: assert property (
    !rf_req.rd |=> $stable(rf_rdata))
    else $error("read data changed without a read");

  unmapped_read_a: assert property (
    (rf_req.rd && !hit_itm && !hit_wdt) |=> (rf_rdata == 4'h0))
    else $error("unmapped address read nonzero");

  mode_read_a: assert property (
    (rf_req.rd && hit_itm) |=> (rf_rdata[ITM_TAP_BIT] == $past(tap_sel)))
    else $error("tap select read back wrong");

endmodule

// ===== hw/itw_pkg.sv
// Constants and types for the interval timer and watchdog block.
// Assumes a 4-bit register file port driven by the CPU core on sys_clk.
//
// Overview of operation
// - Count pulse is clock/16, /16384, /4096, /512.
// - Clear bit written 1 resets the counter.
// - Clear bit self-clears and always reads 0.
// - Tap select picks 1/128 or 1/32 interval.
// - Start bit enables divider, eight-bit watchdog.
// - Software cannot clear the watchdog start bit.
// - Start bit self-clears and always reads 0.
// - Service bit written 1 clears carry flop.
// - Service bit self-clears and always reads 0.
// - Unserviced watchdog raises a system reset.
// - Running watchdog stops only at device reset.
// - Start does not clear counter; clear first.
package itw_pkg;

  // ****************************************************************
  // Register file map
  // ****************************************************************
  localparam int              RF_AW         = 7;
  localparam logic [6:0]      WDT_MODE_ADDR = 7'h03;
  localparam logic [6:0]      ITM_MODE_ADDR = 7'h13;
  localparam int              ITM_TAP_BIT   = 3;
  localparam int              ITM_CLR_BIT   = 2;
  localparam int              ITM_CK_HI_BIT = 1;
  localparam int              ITM_CK_LO_BIT = 0;
  localparam int              WDT_SVC_BIT   = 3;
  localparam int              WDT_START_BIT = 0;
  localparam logic [3:0]      ITM_MODE_RST  = 4'h0;
  localparam logic [3:0]      WDT_MODE_RST  = 4'h0;

  // ****************************************************************
  // Prescaler and counter geometry
  // ****************************************************************
  localparam int              PRE_W         = 14;
  localparam int              CNT_W         = 7;
  localparam logic [13:0]     MASK_DIV16    = 14'h000F;
  localparam logic [13:0]     MASK_DIV16384 = 14'h3FFF;
  localparam logic [13:0]     MASK_DIV4096  = 14'h0FFF;
  localparam logic [13:0]     MASK_DIV512   = 14'h01FF;
  localparam logic [4:0]      TAP32_LAST    = 5'h1F;
  localparam logic [6:0]      TAP128_LAST   = 7'h7F;
  localparam logic [13:0]     PRE_RST       = 14'h0000;
  localparam logic [6:0]      CNT_RST       = 7'h00;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [3:0] data;
  } itw_rf_req_t;

  typedef enum logic [1:0] {
    CK_DIV16,
    CK_DIV16384,
    CK_DIV4096,
    CK_DIV512
  } itw_ck_sel_t;

endpackage

// ===== dv/itw_top_tb.sv
// Self-checking bench for the interval timer and watchdog block.
// Assumes itw_pkg is compiled first; the bench drives rst_b itself.
`timescale 1ns/1ps
module itw_top_tb;
  import itw_pkg::*;
  logic        sys_clk;
  logic        rst_b;
  logic        irq_clear;
  logic        interval_irq;
  logic        wdt_running;
  logic        wdt_reset;
  logic [3:0]  rf_rdata;
  logic [3:0]  m_rdata;
  itw_rf_req_t rf_req;
  int          fail_count;
  int          comparisons;
  int          pre, cnt, carry, run, irq, tap, ck, fire, i, n;

  itw_top u_itw_top (
    .sys_clk      (sys_clk),
    .rst_b        (rst_b),
    .rf_req       (rf_req),
    .rf_rdata     (rf_rdata),
    .irq_clear    (irq_clear),
    .interval_irq (interval_irq),
    .wdt_running  (wdt_running),
    .wdt_reset    (wdt_reset)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // Reference model, updated from the inputs sampled at each edge
  // ****************************************************************
  always @(posedge sys_clk) begin : model
    int mask, pulse, ovf, ev, clr, svc;
    mask = (ck == 0) ? 15 : (ck == 1) ? 16383 : (ck == 2) ? 4095 : 511;
    clr = rf_req.wr && rf_req.addr == 7'h13 && rf_req.data[2];
    svc = rf_req.wr && rf_req.addr == 7'h03 && rf_req.data[3];
    if (!rst_b) begin
      {pre, cnt, carry, run, irq, tap, ck, fire} = '0;
      m_rdata = 4'h0;
    end else begin
      pulse = ((pre & mask) == mask);
      ovf = pulse && cnt == 127;
      ev = pulse && (tap ? (cnt % 32) == 31 : cnt == 127);
      if (rf_req.rd) m_rdata = (rf_req.addr == 7'h13) ? {tap[0], 1'b0, ck[1:0]} : 4'h0;
      fire = run && ovf && carry;
      if (run && ovf) carry = !carry;
      else if (svc) carry = 0;
      irq = ev | (irq & !irq_clear);
      pre = clr ? 0 : (pre + 1) % 16384;
      cnt = clr ? 0 : (cnt + pulse) % 128;
      if (rf_req.wr && rf_req.addr == 7'h13) begin
        tap = rf_req.data[3];
        ck = rf_req.data[1:0];
      end
      if (rf_req.wr && rf_req.addr == 7'h03 && rf_req.data[0]) run = 1;
    end
  end

  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  always @(negedge sys_clk) chk({rf_rdata, interval_irq, wdt_running, wdt_reset}, {m_rdata, irq[0], run[0], fire[0]});

  task automatic acc(input logic wr, input logic rd, input logic [6:0] a, input logic [3:0] d);
    @(posedge sys_clk);
    #1 rf_req = '{wr: wr, rd: rd, addr: a, data: d};
    @(posedge sys_clk);
    #1 rf_req = '0;
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_b = 1'b0;
    rf_req = '0;
    irq_clear = 1'b0;
    fail_count = 0;
    comparisons = 0;
    void'($urandom(32'ha495));
    repeat (10) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    acc(1'b0, 1'b1, 7'h13, 4'h0);
    acc(1'b0, 1'b1, 7'h03, 4'h0);
    acc(1'b1, 1'b1, 7'h05, 4'hF);
    acc(1'b0, 1'b1, 7'h05, 4'h0);
    // Slow codes get only a short run, except code 3 with the 1/32 tap; their intervals exceed the cycle budget.
    for (i = 0; i < 8; i++) begin
      acc(1'b1, 1'b1, 7'h13, {i[2], 1'b1, i[1:0]});
      acc(1'b0, 1'b1, 7'h13, 4'h0);
      n = (i == 0) ? 1100 : (i == 4) ? 600 : (i == 7) ? 8300 : 300;
      repeat (2) begin
        repeat (n) begin
          @(posedge sys_clk);
          #1 irq_clear = ($urandom % 64) == 0;
        end
        acc(1'b1, 1'b0, 7'h13, {i[2], 1'b0, i[1:0]});
      end
    end
    // Slow rates: preload the counter to 31 at the fast rate, then switch the
    // rate without a clear, so that a single slow pulse ends the interval.
    for (i = 1; i < 4; i++) begin
      acc(1'b1, 1'b0, 7'h13, 4'hC);
      irq_clear = 1'b1;
      repeat (500) @(posedge sys_clk);
      #1 irq_clear = 1'b0;
      acc(1'b1, 1'b0, 7'h13, {2'b10, i[1:0]});
      n = (i == 1) ? 16000 : (i == 2) ? 3700 : 100;
      repeat (n) @(posedge sys_clk);
    end
    acc(1'b1, 1'b0, 7'h13, 4'h4);
    acc(1'b1, 1'b1, 7'h03, 4'h1);
    for (i = 0; i < 6; i++) begin
      repeat (800 + $urandom % 200) @(posedge sys_clk);
      acc(1'b1, 1'b0, (i == 3) ? 7'h13 : 7'h03, (i == 3) ? 4'h4 : 4'h8);
    end
    n = 0;
    while (wdt_reset !== 1'b1 && n < 4200) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 4200)
      fail_count++;
    acc(1'b1, 1'b1, 7'h03, 4'h0);
    repeat (4200) @(posedge sys_clk);
    #1 rst_b = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    repeat (50) @(posedge sys_clk);
    end_of_test();
  end
endmodule
